// file: design/rss_defs.vh
/*
 constants of the reset source sequencer: offsets, field positions, reset values and cycle counts.
 assumes it is included by bare name into the sequencer files.
*/
`ifndef RSS_DEFS_VH
`define RSS_DEFS_VH

// ==========================================
// register offsets
`define RSS_OFS_CAUSE 8'h01
`define RSS_OFS_CONFIG 8'h1F

// ==========================================
// cause register bit positions
`define RSS_CAUSE_PWRON 7
`define RSS_CAUSE_PIN 6
`define RSS_CAUSE_WDOG 5
`define RSS_CAUSE_BADOP 4
`define RSS_CAUSE_BADADR 3
`define RSS_CAUSE_MONRST 2
`define RSS_CAUSE_BROWN 1
`define RSS_CAUSE_PWRON_VAL 8'h80
`define RSS_CAUSE_NONE 8'h00

// ==========================================
// config word one fields and reset value
`define RSS_CFG_SHORT_REC 0
`define RSS_CFG_STOP_EN 1
`define RSS_CFG_RESET 2'h0

// ==========================================
// timing in reference clock cycles
`define RSS_PIN_DRIVE_LAST 13'h001F
`define RSS_INT_HOLD_LAST 13'h001F
`define RSS_OSC_STAB_CYC 13'h1000
`define RSS_PIN_MIN_LOW 7'h43
`define RSS_STOP_REC_SHORT_LAST 12'h01F
`define RSS_STOP_REC_LONG_LAST 12'hFFF

// ==========================================
// reset vectors
`define RSS_VEC_USER 16'hFFFE
`define RSS_VEC_MONITOR 16'hFEFE
`define RSS_ZERO8 8'h00

`endif

// file: design/rss_sequencer.v
/*
 reset source sequencer: collects reset sources, records the cause, drives the reset pin,
 holds the internal reset line and times oscillator stabilisation and stop recovery.
 assumes one reference clock, a synchronous power-on reset, and a board pull-up on the pin.
*/
`timescale 1ns/10ps
`include "rss_defs.vh"

module rss_sequencer
#(
	parameter [12:0] POR_HOLD_CYC = 13'h1020
)
(
	// clock and reset
	input wire I_CORE_CLK,
	input wire I_RESET_N,
	// reset pin
	input wire I_RST_PIN,
	output reg O_RST_PIN_OUT,
	output reg O_RST_PIN_OE,
	// reset sources
	input wire I_WDOG_OVF,
	input wire I_BROWNOUT_REQ,
	input wire I_BAD_OPCODE,
	input wire I_STOP_EXEC,
	input wire I_OPCODE_FETCH,
	input wire I_UNMAPPED_ADDR,
	input wire I_MONITOR_ENTRY_RST,
	// mode and test voltage sensing
	input wire I_MONITOR_MODE,
	input wire I_BREAK_STATE,
	input wire I_RST_AT_VTST,
	input wire I_IRQ_AT_VTST,
	input wire I_WAKE,
	// interrupt entry and return
	input wire I_INT_REQ,
	input wire I_RTI_EXEC,
	output reg O_STACK_PULSE,
	output reg O_UNSTACK_PULSE,
	output reg O_IMASK,
	// register port
	input wire [7:0] I_ADDR,
	input wire [7:0] I_WDATA,
	input wire I_WR,
	input wire I_RD,
	output reg [7:0] O_RDATA,
	// system outputs
	output reg O_INT_RESET,
	output reg [15:0] O_RESET_VECTOR,
	output reg O_CLK_GEN_EN,
	output reg O_CPU_CLK_EN,
	output reg O_WDOG_DISABLE,
	output reg O_IN_STOP,
	output reg [11:0] O_PRESCALE
);

	localparam [2:0] ST_RUN = 3'h0;
	localparam [2:0] ST_POR_HOLD = 3'h1;
	localparam [2:0] ST_PIN_DRIVE = 3'h2;
	localparam [2:0] ST_INT_HOLD = 3'h3;
	localparam [2:0] ST_EXT_HOLD = 3'h4;
	localparam [2:0] ST_STOP = 3'h5;
	localparam [2:0] ST_STOP_REC = 3'h6;

	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg [12:0] phase_ff;
	reg [12:0] nxt_phase;
	reg [7:0] cause_ff;
	reg [7:0] nxt_cause;
	reg [1:0] cfg_ff;
	reg pin_sync1_ff;
	reg pin_sync2_ff;
	reg wdog_sync1_ff;
	reg wdog_sync2_ff;
	reg [6:0] low_cnt_ff;
	reg cnt_clr;
	wire [11:0] stab_count;
	wire wdog_off;
	wire pin_low;
	wire illegal_op;
	wire bad_fetch;
	wire int_event;
	wire stop_ok;
	wire rec_done;

	// ==========================================
	// helpers
	function [7:0] one_cause;
		input integer pos;
		begin
			one_cause = `RSS_CAUSE_NONE;
			one_cause[pos] = 1'b1;
		end
	endfunction

	function in_reset;
		input [2:0] st;
		begin
			in_reset = (st == ST_POR_HOLD) || (st == ST_PIN_DRIVE) || (st == ST_INT_HOLD) || (st == ST_EXT_HOLD);
		end
	endfunction

	// ==========================================
	// synchronisers
	// first stage feeds only the second so a metastable value never reaches logic
	always @(posedge I_CORE_CLK)
	begin
		if (!I_RESET_N)
		begin
			pin_sync1_ff <= 1'b1;
			pin_sync2_ff <= 1'b1;
			wdog_sync1_ff <= 1'b0;
			wdog_sync2_ff <= 1'b0;
		end
		else
		begin
			pin_sync1_ff <= I_RST_PIN;
			pin_sync2_ff <= pin_sync1_ff;
			wdog_sync1_ff <= I_WDOG_OVF;
			wdog_sync2_ff <= wdog_sync1_ff;
		end
	end

	// ==========================================
	// source decode
	// the disable is plain gating on the sensed pins, nothing software can set
	assign wdog_off = (I_MONITOR_MODE & (I_RST_AT_VTST | I_IRQ_AT_VTST)) | (I_BREAK_STATE & I_RST_AT_VTST);
	assign pin_low = ~pin_sync2_ff & ~O_RST_PIN_OE;
	assign stop_ok = cfg_ff[`RSS_CFG_STOP_EN];
	assign illegal_op = I_BAD_OPCODE | (I_STOP_EXEC & ~stop_ok);
	assign bad_fetch = I_OPCODE_FETCH & I_UNMAPPED_ADDR;
	assign int_event = (wdog_sync2_ff & ~wdog_off) | illegal_op | bad_fetch | I_MONITOR_ENTRY_RST;
	assign rec_done = cfg_ff[`RSS_CFG_SHORT_REC] ? (stab_count == `RSS_STOP_REC_SHORT_LAST)
		: (stab_count == `RSS_STOP_REC_LONG_LAST);

	// ==========================================
	// stabilisation counter
	rss_stab_counter u_stab
	(
		.i_clk(I_CORE_CLK),
		.i_reset_n(I_RESET_N),
		.i_clr(cnt_clr),
		.i_run(state_ff != ST_STOP),
		.o_count_ff(stab_count)
	);

	// ==========================================
	// sequencer
	always @*
	begin
		nxt_state = state_ff;
		nxt_phase = phase_ff + 13'h0001;
		nxt_cause = cause_ff;
		cnt_clr = 1'b0;
		if (I_BROWNOUT_REQ && state_ff != ST_POR_HOLD)
		begin
			nxt_state = ST_POR_HOLD;
			nxt_phase = 13'h0000;
			nxt_cause = one_cause(`RSS_CAUSE_BROWN);
			cnt_clr = 1'b1;
		end
		else
		begin
			case (state_ff)
				ST_RUN, ST_STOP, ST_STOP_REC:
				begin
					if (int_event)
					begin
						nxt_state = ST_PIN_DRIVE;
						nxt_phase = 13'h0000;
						cnt_clr = 1'b1;
						if (wdog_sync2_ff && !wdog_off)
							nxt_cause = one_cause(`RSS_CAUSE_WDOG);
						else if (illegal_op)
							nxt_cause = one_cause(`RSS_CAUSE_BADOP);
						else if (bad_fetch)
							nxt_cause = one_cause(`RSS_CAUSE_BADADR);
						else
							nxt_cause = one_cause(`RSS_CAUSE_MONRST);
					end
					else if (pin_low)
					begin
						nxt_state = ST_EXT_HOLD;
						nxt_phase = 13'h0000;
					end
					else if (state_ff == ST_RUN && I_STOP_EXEC)
					begin
						nxt_state = ST_STOP;
						cnt_clr = 1'b1;
					end
					else if (state_ff == ST_STOP && I_WAKE)
						nxt_state = ST_STOP_REC;
					else if (state_ff == ST_STOP_REC && rec_done)
						nxt_state = ST_RUN;
				end
				ST_POR_HOLD:
				begin
					if (phase_ff == POR_HOLD_CYC - 13'h0001)
					begin
						nxt_state = ST_INT_HOLD;
						nxt_phase = 13'h0000;
					end
				end
				ST_PIN_DRIVE:
				begin
					if (phase_ff == `RSS_PIN_DRIVE_LAST)
					begin
						nxt_state = ST_INT_HOLD;
						nxt_phase = 13'h0000;
					end
				end
				ST_INT_HOLD:
				begin
					if (phase_ff == `RSS_INT_HOLD_LAST)
						nxt_state = ST_RUN;
				end
				ST_EXT_HOLD:
				begin
					// pin flag only counts when entered from run, stop or stop recovery, never from the long sequence
					if (low_cnt_ff == `RSS_PIN_MIN_LOW - 7'h01 && pin_low)
						nxt_cause = one_cause(`RSS_CAUSE_PIN);
					if (!pin_low)
					begin
						nxt_state = ST_INT_HOLD;
						nxt_phase = 13'h0000;
					end
				end
				default:
				begin
					nxt_state = ST_POR_HOLD;
					nxt_phase = 13'h0000;
				end
			endcase
		end
	end

	always @(posedge I_CORE_CLK)
	begin
		if (!I_RESET_N)
		begin
			state_ff <= ST_POR_HOLD;
			phase_ff <= 13'h0000;
			cause_ff <= `RSS_CAUSE_PWRON_VAL;
			low_cnt_ff <= 7'h00;
		end
		else
		begin
			state_ff <= nxt_state;
			phase_ff <= nxt_phase;
			cause_ff <= nxt_cause;
			if (state_ff == ST_EXT_HOLD && pin_low)
				low_cnt_ff <= (low_cnt_ff == `RSS_PIN_MIN_LOW) ? low_cnt_ff : low_cnt_ff + 7'h01;
			else
				low_cnt_ff <= 7'h00;
		end
	end

	// ==========================================
	// system outputs
	// pin and reset line are registered from the next state so they move with it
	always @(posedge I_CORE_CLK)
	begin
		if (!I_RESET_N)
		begin
			O_RST_PIN_OUT <= 1'b0;
			O_RST_PIN_OE <= 1'b1;
			O_INT_RESET <= 1'b1;
			O_RESET_VECTOR <= `RSS_VEC_USER;
			O_CLK_GEN_EN <= 1'b1;
			O_CPU_CLK_EN <= 1'b0;
			O_WDOG_DISABLE <= 1'b0;
			O_IN_STOP <= 1'b0;
			O_PRESCALE <= 12'h000;
		end
		else
		begin
			O_RST_PIN_OUT <= 1'b0;
			O_RST_PIN_OE <= (nxt_state == ST_POR_HOLD) || (nxt_state == ST_PIN_DRIVE);
			O_INT_RESET <= in_reset(nxt_state);
			O_RESET_VECTOR <= I_MONITOR_MODE ? `RSS_VEC_MONITOR : `RSS_VEC_USER;
			O_CLK_GEN_EN <= (nxt_state != ST_STOP);
			O_CPU_CLK_EN <= !((nxt_state == ST_POR_HOLD && nxt_phase < `RSS_OSC_STAB_CYC)
				|| nxt_state == ST_STOP || nxt_state == ST_STOP_REC);
			O_WDOG_DISABLE <= wdog_off;
			O_IN_STOP <= (nxt_state == ST_STOP) || (nxt_state == ST_STOP_REC);
			O_PRESCALE <= stab_count;
		end
	end

	// ==========================================
	// interrupt entry and return
	always @(posedge I_CORE_CLK)
	begin
		if (!I_RESET_N)
		begin
			O_STACK_PULSE <= 1'b0;
			O_UNSTACK_PULSE <= 1'b0;
			O_IMASK <= 1'b1;
		end
		else
		begin
			O_STACK_PULSE <= I_INT_REQ && !O_IMASK && state_ff == ST_RUN;
			O_UNSTACK_PULSE <= I_RTI_EXEC && state_ff == ST_RUN;
			if (in_reset(state_ff))
				O_IMASK <= 1'b1;
			else if (I_INT_REQ && !O_IMASK && state_ff == ST_RUN)
				O_IMASK <= 1'b1;
			else if (I_RTI_EXEC && state_ff == ST_RUN)
				O_IMASK <= 1'b0;
		end
	end

	// ==========================================
	// register port
	// config is a register of its own; the cause byte ignores every write
	always @(posedge I_CORE_CLK)
	begin
		if (!I_RESET_N || in_reset(state_ff))
			cfg_ff <= `RSS_CFG_RESET;
		else if (I_WR && I_ADDR == `RSS_OFS_CONFIG)
			cfg_ff <= I_WDATA[1:0];
	end

	always @(posedge I_CORE_CLK)
	begin
		if (!I_RESET_N)
			O_RDATA <= `RSS_ZERO8;
		else if (I_RD && I_ADDR == `RSS_OFS_CAUSE)
			O_RDATA <= cause_ff;
		else if (I_RD && I_ADDR == `RSS_OFS_CONFIG)
			O_RDATA <= {6'h00, cfg_ff};
		else
			O_RDATA <= `RSS_ZERO8;
	end

endmodule // rss_sequencer

// file: design/rss_stab_counter.v
/*
 12-bit stabilisation counter of the reset source sequencer.
 assumes a synchronous active low reset and one clock, the reference clock.
*/
`timescale 1ns/10ps
`include "rss_defs.vh"

module rss_stab_counter
(
	// clock and reset
	input wire i_clk,
	input wire i_reset_n,
	// control
	input wire i_clr,
	input wire i_run,
	// count
	output reg [11:0] o_count_ff
);

	wire [11:0] nxt_count;

	// ==========================================
	// counter
	// clear beats run so a stop entry always restarts recovery from zero
	assign nxt_count = i_clr ? 12'h000 : (i_run ? o_count_ff + 12'h001 : o_count_ff);

	always @(posedge i_clk)
	begin
		if (!i_reset_n)
			o_count_ff <= 12'h000;
		else
			o_count_ff <= nxt_count;
	end

endmodule // rss_stab_counter

// file: test/rss_pin_model.sv
/*
 board side of the reset pin: pull-up plus an outside agent that can pull it low.
 assumes the device drives the pin open drain through its enable.
*/
`timescale 1ns/10ps

module rss_pin_model
(
	// drive
	input wire i_oe,
	input wire i_out,
	input wire i_agent_low,
	// wire level
	output wire o_pin
);
	// pull-up wins only when nobody pulls low
	assign o_pin = ((i_oe && !i_out) || i_agent_low) ? 1'b0 : 1'b1;
endmodule // rss_pin_model

// file: test/rss_sequencer_chk.sv
/*
 concurrent checks on the reset source sequencer ports.
 assumes bind onto rss_sequencer with one clock domain.
*/
`timescale 1ns/10ps
`include "rss_defs.vh"

module rss_sequencer_chk
(
	input wire I_CORE_CLK,
	input wire I_RESET_N,
	input wire I_BAD_OPCODE,
	input wire I_STOP_EXEC,
	input wire I_MONITOR_MODE,
	input wire I_BREAK_STATE,
	input wire I_RST_AT_VTST,
	input wire I_IRQ_AT_VTST,
	input wire I_INT_REQ,
	input wire I_RD,
	input wire O_RST_PIN_OUT,
	input wire O_RST_PIN_OE,
	input wire O_STACK_PULSE,
	input wire O_IMASK,
	input wire [7:0] O_RDATA,
	input wire O_INT_RESET,
	input wire [15:0] O_RESET_VECTOR,
	input wire O_CLK_GEN_EN,
	input wire O_CPU_CLK_EN,
	input wire O_WDOG_DISABLE,
	input wire O_IN_STOP
);
	reg [12:0] oe_cnt_ff;
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RESET_N);
	// ==========================================
	// length of the pin drive, long sequences excluded
	always @(posedge I_CORE_CLK)
	begin
		if (!I_RESET_N)
			oe_cnt_ff <= 13'h0000;
		else
			oe_cnt_ff <= O_RST_PIN_OE ? oe_cnt_ff + 13'h0001 : 13'h0000;
	end
	// ==========================================
	// assertions
	a_pin_out_low: assert property (O_RST_PIN_OUT == 1'b0)
		else $error("pin drive value not low");
	a_pin_needs_int: assert property (O_RST_PIN_OE |-> O_INT_RESET)
		else $error("pin low without reset");
	a_badop_resets: assert property ((I_BAD_OPCODE && !O_INT_RESET && !O_IN_STOP)
		|=> O_INT_RESET && O_RST_PIN_OE) else $error("bad opcode did not reset");
	a_pin_drive_len: assert property (($fell(O_RST_PIN_OE) && oe_cnt_ff < 13'h0040)
		|-> oe_cnt_ff == 13'h0020) else $error("pin drive not 32 cycles");
	a_hold_release: assert property ($fell(O_RST_PIN_OE) |-> ##31 O_INT_RESET ##1 !O_INT_RESET)
		else $error("internal hold not 32 cycles");
	a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
		else $error("read data outside slot");
	a_vector_pick: assert property ($fell(O_INT_RESET) |-> O_RESET_VECTOR ==
		($past(I_MONITOR_MODE) ? `RSS_VEC_MONITOR : `RSS_VEC_USER)) else $error("wrong vector");
	a_wdog_disable: assert property ($past(I_RESET_N) |-> O_WDOG_DISABLE ==
		$past((I_MONITOR_MODE && (I_RST_AT_VTST || I_IRQ_AT_VTST)) || (I_BREAK_STATE && I_RST_AT_VTST)))
		else $error("watchdog disable");
	a_stop_clocks: assert property ($rose(O_IN_STOP) |-> $past(I_STOP_EXEC)
		&& !O_CLK_GEN_EN && !O_CPU_CLK_EN) else $error("stop clocks");
	a_stack_entry: assert property ((I_INT_REQ && !O_IMASK && !O_INT_RESET && !O_IN_STOP)
		|=> O_STACK_PULSE && O_IMASK) else $error("interrupt entry");
endmodule // rss_sequencer_chk

bind rss_sequencer rss_sequencer_chk rss_sequencer_chk_i (.*);

// file: test/rss_sequencer_tb.sv
/*
 self-checking bench of the reset source sequencer.
 assumes the pin model and the bound checker; short power hold of 80 cycles.
*/
`timescale 1ns/10ps
`include "rss_defs.vh"

module rss_sequencer_tb;
	reg clk = 0, rst_n = 0, mon = 0, vtst = 0, wake = 0, irq = 0, return_from_interrupt = 0, wr = 0, rd = 0, ext_low = 0;
	reg [6:0] src = 7'h00;
	reg [7:0] addr = 8'h00, wdata = 8'h00, last;
	reg [16:0] seed = 17'h13FF8;
	reg [11:0] p0;
	integer fail_count = 0, check_count = 0, n, k;
	wire pin, pout, poe, internal_reset_line, stk, unstk, imask, cg, cpu, wdis, istop;
	wire [7:0] rdata;
	wire [15:0] vec;
	wire [11:0] pre;
	rss_pin_model rss_pin_model_i (.i_oe(poe), .i_out(pout), .i_agent_low(ext_low), .o_pin(pin));
	rss_sequencer #(.POR_HOLD_CYC(13'h0050)) rss_sequencer_i (.I_CORE_CLK(clk), .I_RESET_N(rst_n),
		.I_RST_PIN(pin), .O_RST_PIN_OUT(pout), .O_RST_PIN_OE(poe), .I_WDOG_OVF(src[5]),
		.I_BROWNOUT_REQ(src[6]), .I_BAD_OPCODE(src[0]), .I_STOP_EXEC(src[1]), .I_OPCODE_FETCH(src[2]),
		.I_UNMAPPED_ADDR(src[3]), .I_MONITOR_ENTRY_RST(src[4]), .I_MONITOR_MODE(mon), .I_BREAK_STATE(1'b0),
		.I_RST_AT_VTST(vtst), .I_IRQ_AT_VTST(1'b0), .I_WAKE(wake), .I_INT_REQ(irq), .I_RTI_EXEC(return_from_interrupt),
		.O_STACK_PULSE(stk), .O_UNSTACK_PULSE(unstk), .O_IMASK(imask), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_INT_RESET(internal_reset_line), .O_RESET_VECTOR(vec), .O_CLK_GEN_EN(cg),
		.O_CPU_CLK_EN(cpu), .O_WDOG_DISABLE(wdis), .O_IN_STOP(istop), .O_PRESCALE(pre));
	// ==========================================
	// helpers
	function [16:0] lfsr(input [16:0] s);
		lfsr = {s[15:0], s[16] ^ s[13]};
	endfunction
	// priority of simultaneous sources, most recent cause only
	function [7:0] cause_of(input [6:0] s);
		cause_of = s[6] ? 8'h01 << `RSS_CAUSE_BROWN : s[5] ? 8'h01 << `RSS_CAUSE_WDOG :
			(s[0] | s[1]) ? 8'h01 << `RSS_CAUSE_BADOP : (s[2] & s[3]) ? 8'h01 << `RSS_CAUSE_BADADR :
			s[4] ? 8'h01 << `RSS_CAUSE_MONRST : `RSS_CAUSE_NONE;
	endfunction
	task chk(input [15:0] got, input [15:0] exp);
	begin
		check_count = check_count + 1;
		if (got !== exp)
		begin
			fail_count = fail_count + 1;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task stop_test;
	begin
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask
	task settle;
	begin
		n = 0;
		while (internal_reset_line !== 1'b0 && n < 5000)
		begin
			@(negedge clk);
			n = n + 1;
		end
		chk(n < 5000, 1);
	end
	endtask
	task access(input w, input [7:0] a, input [7:0] d, input [7:0] e);
	begin
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		@(negedge clk);
		if (!w)
			chk(rdata, e);
	end
	endtask
	// a source held three cycles covers the watchdog synchroniser
	task fire(input [6:0] s, input [7:0] e);
	begin
		repeat (150) @(posedge clk);
		src <= s;
		repeat (3) @(posedge clk);
		src <= 7'h00;
		@(posedge clk);
		@(negedge clk);
		chk(internal_reset_line, e != 8'h00);
		if (e != 8'h00)
		begin
			settle;
			chk(pre < 12'h080, 1);
			access(0, `RSS_OFS_CAUSE, 8'h00, e);
			last = e;
		end
		$display("source test %h done", s);
	end
	endtask
	task ext(input [7:0] len, input [7:0] e);
	begin
		repeat (149) @(posedge clk);
		@(negedge clk);
		p0 = pre;
		@(posedge clk);
		ext_low <= 1'b1;
		repeat (len) @(posedge clk);
		ext_low <= 1'b0;
		@(negedge clk);
		chk(internal_reset_line, 1);
		settle;
		chk(pre - p0 > len && pre - p0 < len + 12'h040, 1);
		access(0, `RSS_OFS_CAUSE, 8'h00, e);
		last = e;
		$display("pin test %0d done", len);
	end
	endtask
	// ==========================================
	// stimulus
	initial
	begin
		forever #50 clk = !clk;
	end
	initial
	begin
		#4000000;
		fail_count = fail_count + 1;
		stop_test;
	end
	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk(poe & internal_reset_line & cg & !cpu, 1);
		settle;
		access(0, `RSS_OFS_CAUSE, 8'h00, `RSS_CAUSE_PWRON_VAL);
		seed = lfsr(seed);
		access(1, `RSS_OFS_CAUSE, seed[7:0], 8'h00);
		access(0, `RSS_OFS_CAUSE, 8'h00, `RSS_CAUSE_PWRON_VAL);
		access(0, 8'h55, 8'h00, 8'h00);
		@(posedge clk);
		return_from_interrupt <= 1'b1;
		@(posedge clk);
		return_from_interrupt <= 1'b0;
		@(negedge clk);
		chk({unstk, imask}, 2'b10);
		@(posedge clk);
		irq <= 1'b1;
		@(posedge clk);
		irq <= 1'b0;
		@(negedge clk);
		chk({stk, imask}, 2'b11);
		$display("register and interrupt test done");
		fire(7'h08, 8'h00);
		for (k = 0; k < 7; k = k + 1)
			fire(7'h01 << k, cause_of(7'h01 << k));
		for (k = 0; k < 4; k = k + 1)
		begin
			seed = lfsr(seed);
			fire(seed[6:0] & 7'h5F | 7'h10, cause_of(seed[6:0] & 7'h5F | 7'h10));
		end
		seed = lfsr(seed);
		ext(8'h05 + seed[7:0] % 40, last);
		seed = lfsr(seed);
		ext(8'h46 + seed[7:0] % 30, 8'h01 << `RSS_CAUSE_PIN);
		@(posedge clk);
		mon <= 1'b1;
		vtst <= 1'b1;
		fire(7'h20, 8'h00);
		chk(wdis, 1);
		fire(7'h01, cause_of(7'h01));
		chk(vec, `RSS_VEC_MONITOR);
		@(posedge clk);
		mon <= 1'b0;
		vtst <= 1'b0;
		for (k = 3; k > 1; k = k - 1)
		begin
			access(1, `RSS_OFS_CONFIG, k[7:0], 8'h00);
			@(posedge clk);
			src <= 7'h02;
			@(posedge clk);
			src <= 7'h00;
			repeat (20) @(posedge clk);
			@(negedge clk);
			chk({istop, cpu, cg, pre}, 15'h4000);
			@(posedge clk);
			wake <= 1'b1;
			@(posedge clk);
			wake <= 1'b0;
			n = 0;
			while (cpu !== 1'b1 && n < 5000)
			begin
				@(negedge clk);
				n = n + 1;
			end
			chk(k == 3 ? (n > 28 && n < 40) : (n > 4088 && n < 4104), 1);
			$display("stop test %0d done", k);
		end
		stop_test;
	end
endmodule // rss_sequencer_tb
